/* rtl/pcr_cfg.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef PCR_CFG_SVH
`define PCR_CFG_SVH

// ==========================================================
// Offsets
`define PCR_OFF_LOCK        8'h00
`define PCR_OFF_OVERRIDE    8'h2D
`define PCR_OFF_SHED_TIME   8'h4A
`define PCR_OFF_SCRATCH     8'h4B
`define PCR_OFF_FILT_PD     8'h4C
`define PCR_OFF_OC_EN       8'h4D
`define PCR_OFF_MID_DRV     8'h4E
`define PCR_OFF_PH_RAMP     8'h4F
`define PCR_OFF_STATUS      8'h60

// ==========================================================
// Lock value and fields
`define PCR_LOCK_VALUE      8'hA6
`define PCR_OVR_BIT         2
`define PCR_FILT_LSB        5
`define PCR_CCM_PD_LSB      2
`define PCR_DEM_PD_LSB      0
`define PCR_OC_ANALOG_BIT   1
`define PCR_OC_DIGITAL_BIT  0
`define PCR_MID_HOLD_BIT    1
`define PCR_MID_BRIEF_BIT   0
`define PCR_PHASE_LSB       4
`define PCR_RAMP_LSB        0

// ==========================================================
// Reset values
`define PCR_RST_LOCK        8'h00
`define PCR_RST_OVERRIDE    8'h00
`define PCR_RST_SHED_TIME   6'h13
`define PCR_RST_SCRATCH     8'h00
`define PCR_RST_FILT_PD     7'h2A
`define PCR_RST_OC_EN       2'h0
`define PCR_RST_MID_DRV     3'h5
`define PCR_RST_PH_RAMP     7'h03

// ==========================================================
// Timing (clock 50 MHz)
`define PCR_CLK_MHZ         50
`define PCR_DEM_WAIT_NS     40000
`define PCR_DEM_WAIT_CYC    ((`PCR_DEM_WAIT_NS * `PCR_CLK_MHZ) / 1000)
`define PCR_BRIEF_NS        200
`define PCR_BRIEF_CYC       ((`PCR_BRIEF_NS * `PCR_CLK_MHZ) / 1000)

`endif

/* rtl/pcr_pkg.sv */
// Types shared by the configuration register block
package pcr_pkg;
    typedef logic [7:0] pcr_byte_t;
    typedef enum logic [1:0] {
        PCR_FILT_LONG,
        PCR_FILT_MID,
        PCR_FILT_SHORT,
        PCR_FILT_BYPASS
    } pcr_filt_t;
    typedef enum logic [1:0] {
        PCR_DEM_PD_OFF,
        PCR_DEM_PD_1P5MA,
        PCR_DEM_PD_3MA,
        PCR_DEM_PD_5MA
    } pcr_dem_pd_t;
    localparam int PCR_PHASES = 8;
endpackage : pcr_pkg

/* rtl/pcr_phase_if.sv */
// Per-phase conduction signals passed to the phase timer
`timescale 1ns/100ps
interface pcr_phase_if;
    logic [7:0] pwm_tristate;
    logic [7:0] zero_cross;
    logic       dem_active;
    logic       brief_en;
    logic [7:0] pd_enable;
    logic [7:0] brief_drive;
    modport ctrl (output pwm_tristate, output zero_cross, output dem_active,
                  output brief_en, input pd_enable, input brief_drive);
    modport timer (input pwm_tristate, input zero_cross, input dem_active,
                   input brief_en, output pd_enable, output brief_drive);
endinterface : pcr_phase_if

/* rtl/pcr_phase_timer.sv */
// Per-phase tri-state dwell and brief mid-level timers
`timescale 1ns/100ps
`include "pcr_cfg.svh"
module pcr_phase_timer (
    input  wire logic clk,
    input  wire logic sys_rst,
    pcr_phase_if.timer ph
);
    localparam int DW = 12;
    localparam logic [DW-1:0] DEM_CYC   = DW'(`PCR_DEM_WAIT_CYC);
    localparam logic [3:0]    BRIEF_CYC = 4'(`PCR_BRIEF_CYC);

    // ==========================================================
    // Per phase timers
    genvar g;
    generate
        for (g = 0; g < pcr_pkg::PCR_PHASES; g++) begin : g_ph
            logic [DW-1:0] dwell_r;
            logic [3:0]    brief_r;
            logic          zc_d_r;
            // Pull-down only after more than the dwell time at mid level
            always_ff @(posedge clk) begin
                if (sys_rst || !ph.dem_active || !ph.pwm_tristate[g]) begin
                    dwell_r <= '0;
                end else if (dwell_r <= DEM_CYC) begin
                    dwell_r <= dwell_r + 1'b1;
                end
            end
            assign ph.pd_enable[g] = (dwell_r > DEM_CYC);
            // Zero-cross edge starts a fixed mid-level drive, then floats
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    zc_d_r  <= 1'b0;
                    brief_r <= '0;
                end else begin
                    zc_d_r <= ph.zero_cross[g];
                    if (ph.brief_en && ph.dem_active && ph.zero_cross[g] && !zc_d_r) begin
                        brief_r <= BRIEF_CYC;
                    end else if (brief_r != 4'h0) begin
                        brief_r <= brief_r - 1'b1;
                    end
                end
            end
            assign ph.brief_drive[g] = (brief_r != 4'h0);
        end
    endgenerate
endmodule : pcr_phase_timer

/* rtl/pcr_regs.sv */
// Configuration register bank with APB slave and phase control outputs
`timescale 1ns/100ps
`include "pcr_cfg.svh"

// How it works
// - shed timing needs unlock and state-high or override
// - other registers except lock and override writable only while unlocked
// - scratch byte, resets zero, no effect
// - filter delay code, 11 bypasses
// - continuous pull-down code, resets 010
// - discontinuous pull-down after 40us at mid level
// - discontinuous pull-down code, resets 3mA
// - analog overcurrent enable, resets off
// - digital overcurrent flag enable, resets off
// - resistive hold keeps mid level drive
// - zero cross gives 200ns mid drive
// - low-state phase count is code plus one
// - ramp amplitude code, resets 0011
module pcr_regs (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        power_state_input,
    input  wire logic        discontinuous_conduction,
    input  wire logic [7:0]  pwm_tristate,
    input  wire logic [7:0]  zero_cross,
    input  wire logic [7:0]  phase_oc_flag,
    output logic [1:0]       ref_filter_sel,
    output logic [2:0]       ccm_pulldown_code,
    output logic [1:0]       dem_pulldown_code,
    output logic [7:0]       output_sense_pd_en,
    output logic             oc_analog_en,
    output logic [7:0]       oc_flag_out,
    output logic             resistive_hold_drive,
    output logic [7:0]       brief_midlevel_drive,
    output logic [3:0]       active_phases,
    output logic [3:0]       ramp_code
);
    // ==========================================================
    // Storage
    pcr_pkg::pcr_byte_t lock_r;
    pcr_pkg::pcr_byte_t override_r;
    logic [5:0]         shed_time_r;
    pcr_pkg::pcr_byte_t scratch_r;
    logic [6:0]         filt_pd_r;
    logic [1:0]         oc_en_r;
    logic [2:0]         mid_drv_r;
    logic [6:0]         ph_ramp_r;

    // ==========================================================
    // Input synchronisers (three stages, change taken when 2 and 3 agree)
    logic [2:0]  psi_s_r;
    logic        psi_r;
    logic [2:0]  dem_s_r;
    logic        dem_r;
    logic [7:0]  tri_s1_r, tri_s2_r, tri_s3_r, tri_r;
    logic [7:0]  zc_s1_r, zc_s2_r, zc_s3_r, zc_r;
    logic [7:0]  ocf_s1_r, ocf_s2_r, ocf_s3_r, ocf_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            psi_s_r <= '0;
            psi_r   <= 1'b0;
            dem_s_r <= '0;
            dem_r   <= 1'b0;
        end else begin
            psi_s_r <= {psi_s_r[1:0], power_state_input};
            dem_s_r <= {dem_s_r[1:0], discontinuous_conduction};
            if (psi_s_r[1] == psi_s_r[2]) begin
                psi_r <= psi_s_r[2];
            end
            if (dem_s_r[1] == dem_s_r[2]) begin
                dem_r <= dem_s_r[2];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tri_s1_r <= '0; tri_s2_r <= '0; tri_s3_r <= '0; tri_r <= '0;
            zc_s1_r  <= '0; zc_s2_r  <= '0; zc_s3_r  <= '0; zc_r  <= '0;
            ocf_s1_r <= '0; ocf_s2_r <= '0; ocf_s3_r <= '0; ocf_r <= '0;
        end else begin
            tri_s1_r <= pwm_tristate;
            tri_s2_r <= tri_s1_r;
            tri_s3_r <= tri_s2_r;
            tri_r    <= (tri_s2_r & tri_s3_r) | (tri_r & (tri_s2_r | tri_s3_r));
            zc_s1_r  <= zero_cross;
            zc_s2_r  <= zc_s1_r;
            zc_s3_r  <= zc_s2_r;
            zc_r     <= (zc_s2_r & zc_s3_r) | (zc_r & (zc_s2_r | zc_s3_r));
            ocf_s1_r <= phase_oc_flag;
            ocf_s2_r <= ocf_s1_r;
            ocf_s3_r <= ocf_s2_r;
            ocf_r    <= (ocf_s2_r & ocf_s3_r) | (ocf_r & (ocf_s2_r | ocf_s3_r));
        end
    end

    // ==========================================================
    // APB decode
    logic       wr_acc;
    logic [7:0] word_addr;
    logic       unlocked;
    logic       shed_ok;
    logic       addr_hit;

    assign wr_acc    = psel && penable && pwrite;
    assign word_addr = paddr[9:2];
    // Offsets such as 2D and 4B are not multiples of four, so each offset is a word index
    assign unlocked  = (lock_r != `PCR_LOCK_VALUE);
    assign shed_ok   = unlocked && (psi_r || override_r[`PCR_OVR_BIT]);

    always_comb begin
        unique case (word_addr)
            `PCR_OFF_LOCK, `PCR_OFF_OVERRIDE, `PCR_OFF_SHED_TIME, `PCR_OFF_SCRATCH,
            `PCR_OFF_FILT_PD, `PCR_OFF_OC_EN, `PCR_OFF_MID_DRV, `PCR_OFF_PH_RAMP,
            `PCR_OFF_STATUS: addr_hit = (paddr[31:10] == '0) && (paddr[1:0] == 2'b00);
            default:         addr_hit = 1'b0;
        endcase
    end

    // ==========================================================
    // Lock and override stay writable so software can unlock again
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lock_r     <= `PCR_RST_LOCK;
            override_r <= `PCR_RST_OVERRIDE;
        end else if (wr_acc && addr_hit) begin
            if (word_addr == `PCR_OFF_LOCK) begin
                lock_r <= pwdata[7:0];
            end
            if (word_addr == `PCR_OFF_OVERRIDE) begin
                override_r <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            shed_time_r <= `PCR_RST_SHED_TIME;
        end else if (wr_acc && addr_hit && word_addr == `PCR_OFF_SHED_TIME && shed_ok) begin
            shed_time_r <= pwdata[5:0];
        end
    end

    // Blocked writes still complete on the bus without error
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            scratch_r <= `PCR_RST_SCRATCH;
            filt_pd_r <= `PCR_RST_FILT_PD;
            oc_en_r   <= `PCR_RST_OC_EN;
            mid_drv_r <= `PCR_RST_MID_DRV;
            ph_ramp_r <= `PCR_RST_PH_RAMP;
        end else if (wr_acc && addr_hit && unlocked) begin
            unique case (word_addr)
                `PCR_OFF_SCRATCH: scratch_r <= pwdata[7:0];
                `PCR_OFF_FILT_PD: filt_pd_r <= pwdata[6:0];
                `PCR_OFF_OC_EN:   oc_en_r   <= pwdata[1:0];
                `PCR_OFF_MID_DRV: mid_drv_r <= pwdata[2:0];
                `PCR_OFF_PH_RAMP: ph_ramp_r <= pwdata[6:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Read path, registered; answer in the access cycle
    logic [31:0] rd_nxt;
    always_comb begin
        rd_nxt = 32'h0000_0000;
        unique case (word_addr)
            `PCR_OFF_LOCK:      rd_nxt[7:0] = lock_r;
            `PCR_OFF_OVERRIDE:  rd_nxt[7:0] = override_r;
            `PCR_OFF_SHED_TIME: rd_nxt[5:0] = shed_time_r;
            `PCR_OFF_SCRATCH:   rd_nxt[7:0] = scratch_r;
            `PCR_OFF_FILT_PD:   rd_nxt[6:0] = filt_pd_r;
            `PCR_OFF_OC_EN:     rd_nxt[1:0] = oc_en_r;
            `PCR_OFF_MID_DRV:   rd_nxt[2:0] = mid_drv_r;
            `PCR_OFF_PH_RAMP:   rd_nxt[6:0] = ph_ramp_r;
            `PCR_OFF_STATUS:    rd_nxt[11:0] = {unlocked, shed_ok, psi_r, dem_r, oc_flag_out};
            default:            rd_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            // Ready in the first access cycle, low otherwise
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addr_hit;
            prdata  <= (psel && !penable && !pwrite && addr_hit) ? rd_nxt : 32'h0000_0000;
        end
    end

    // ==========================================================
    // Phase timers
    pcr_phase_if ph ();
    assign ph.pwm_tristate = tri_r;
    assign ph.zero_cross   = zc_r;
    assign ph.dem_active   = dem_r;
    assign ph.brief_en     = mid_drv_r[`PCR_MID_BRIEF_BIT];

    pcr_phase_timer u_timer (
        .clk     (clk),
        .sys_rst (sys_rst),
        .ph      (ph.timer)
    );

    // ==========================================================
    // Registered control outputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ref_filter_sel       <= 2'h0;
            ccm_pulldown_code    <= 3'h0;
            dem_pulldown_code    <= 2'h0;
            output_sense_pd_en   <= 8'h00;
            oc_analog_en         <= 1'b0;
            oc_flag_out          <= 8'h00;
            resistive_hold_drive <= 1'b0;
            brief_midlevel_drive <= 8'h00;
            active_phases        <= 4'h0;
            ramp_code            <= 4'h0;
        end else begin
            ref_filter_sel    <= filt_pd_r[`PCR_FILT_LSB +: 2];
            ccm_pulldown_code <= filt_pd_r[`PCR_CCM_PD_LSB +: 3];
            dem_pulldown_code <= filt_pd_r[`PCR_DEM_PD_LSB +: 2];
            // DISCONTINUOUS_CONDUCTION current only after dwell; CONTINUOUS_CONDUCTION current applies otherwise
            output_sense_pd_en <= dem_r ? ph.pd_enable : 8'hFF;
            oc_analog_en      <= oc_en_r[`PCR_OC_ANALOG_BIT];
            oc_flag_out       <= oc_en_r[`PCR_OC_DIGITAL_BIT] ? ocf_r : 8'h00;
            resistive_hold_drive <= mid_drv_r[`PCR_MID_HOLD_BIT];
            brief_midlevel_drive <= ph.brief_drive;
            // High state uses all phases; low state uses code plus one
            active_phases <= psi_r ? 4'h8 : ({1'b0, ph_ramp_r[`PCR_PHASE_LSB +: 3]} + 4'h1);
            ramp_code     <= ph_ramp_r[`PCR_RAMP_LSB +: 4];
        end
    end
endmodule : pcr_regs

/* bench/pcr_regs_assertions.sv */
// Port-level checks for the configuration register block
`timescale 1ns/100ps
`include "pcr_cfg.svh"
module pcr_regs_assertions (
    input logic        clk,
    input logic        sys_rst,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic        pready,
    input logic [31:0] paddr,
    input logic [31:0] pwdata,
    input logic        discontinuous_conduction,
    input logic [7:0]  pwm_tristate,
    input logic [1:0]  ref_filter_sel,
    input logic [2:0]  ccm_pulldown_code,
    input logic [1:0]  dem_pulldown_code,
    input logic [7:0]  output_sense_pd_en,
    input logic        oc_analog_en,
    input logic [7:0]  brief_midlevel_drive,
    input logic [3:0]  ramp_code
);
    localparam int DEM_WAIT = `PCR_DEM_WAIT_CYC;
    localparam logic [31:0] A_FILT = {22'h0, `PCR_OFF_FILT_PD, 2'h0};
    localparam logic [31:0] A_OC = {22'h0, `PCR_OFF_OC_EN, 2'h0};
    localparam logic [31:0] A_PH = {22'h0, `PCR_OFF_PH_RAMP, 2'h0};
    logic        wr_ok;
    logic        locked_r;
    logic [31:0] wd_r;
    logic [11:0] tri_cnt_r;
    // ==========================================================
    // Helper state: the lock is mirrored so blocked writes are told apart
    assign wr_ok = psel && penable && pready && pwrite && !locked_r;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            locked_r <= 1'b0;
        end else if (psel && penable && pready && pwrite && paddr == 32'h0) begin
            locked_r <= pwdata[7:0] == `PCR_LOCK_VALUE;
        end
    end
    always_ff @(posedge clk) begin
        if (wr_ok) begin
            wd_r <= pwdata;
        end
    end
    // Saturates so a long dwell cannot wrap back below the threshold
    always_ff @(posedge clk) begin
        if (sys_rst || !(discontinuous_conduction && pwm_tristate[0])) begin
            tri_cnt_r <= 12'h000;
        end else if (tri_cnt_r != 12'hFFF) begin
            tri_cnt_r <= tri_cnt_r + 12'h001;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ==========================================================
    // Properties
    property p_ref_filter;
        wr_ok && paddr == A_FILT |=> ##[0:1] ref_filter_sel == wd_r[6:5];
    endproperty
    a_ref_filter: assert property (p_ref_filter) else $error("filter select wrong");
    property p_ccm_code;
        wr_ok && paddr == A_FILT |=> ##[0:1] ccm_pulldown_code == wd_r[4:2];
    endproperty
    a_ccm_code: assert property (p_ccm_code) else $error("ccm code wrong");
    property p_dem_code;
        wr_ok && paddr == A_FILT |=> ##[0:1] dem_pulldown_code == wd_r[1:0];
    endproperty
    a_dem_code: assert property (p_dem_code) else $error("dem code wrong");
    property p_locked_keep;
        psel && penable && pready && pwrite && locked_r && paddr == A_FILT
            |=> $stable({ref_filter_sel, ccm_pulldown_code, dem_pulldown_code}) [*3];
    endproperty
    a_locked_keep: assert property (p_locked_keep) else $error("locked write took effect");
    property p_oc_analog;
        wr_ok && paddr == A_OC |=> ##[0:1] oc_analog_en == wd_r[1];
    endproperty
    a_oc_analog: assert property (p_oc_analog) else $error("analog enable wrong");
    property p_ramp;
        wr_ok && paddr == A_PH |=> ##[0:1] ramp_code == wd_r[3:0];
    endproperty
    a_ramp: assert property (p_ramp) else $error("ramp code wrong");
    property p_dem_wait;
        $rose(output_sense_pd_en[0]) && discontinuous_conduction |-> tri_cnt_r > DEM_WAIT;
    endproperty
    a_dem_wait: assert property (p_dem_wait) else $error("pull-down came early");
    property p_brief_len;
        $rose(brief_midlevel_drive[1]) |-> brief_midlevel_drive[1] [*8]
            ##1 brief_midlevel_drive[1] ##1 brief_midlevel_drive[1] ##1 !brief_midlevel_drive[1];
    endproperty
    a_brief_len: assert property (p_brief_len) else $error("brief drive length wrong");
endmodule : pcr_regs_assertions

bind pcr_regs pcr_regs_assertions u_chk (.clk, .sys_rst, .psel, .penable, .pwrite, .pready,
    .paddr, .pwdata, .discontinuous_conduction, .pwm_tristate, .ref_filter_sel,
    .ccm_pulldown_code, .dem_pulldown_code, .output_sense_pd_en, .oc_analog_en,
    .brief_midlevel_drive, .ramp_code);

/* bench/tb_pcr_regs.sv */
// Self-checking bench for the configuration register block
`timescale 1ns/100ps
`include "pcr_cfg.svh"
module tb_pcr_regs;
    localparam logic [31:0] A_LOCK = {22'h0, `PCR_OFF_LOCK, 2'h0};
    localparam logic [31:0] A_OVR = {22'h0, `PCR_OFF_OVERRIDE, 2'h0};
    localparam logic [31:0] A_SHED = {22'h0, `PCR_OFF_SHED_TIME, 2'h0};
    localparam logic [31:0] A_SCR = {22'h0, `PCR_OFF_SCRATCH, 2'h0};
    localparam logic [31:0] A_FILT = {22'h0, `PCR_OFF_FILT_PD, 2'h0};
    localparam logic [31:0] A_OC = {22'h0, `PCR_OFF_OC_EN, 2'h0};
    localparam logic [31:0] A_MID = {22'h0, `PCR_OFF_MID_DRV, 2'h0};
    localparam logic [31:0] A_PH = {22'h0, `PCR_OFF_PH_RAMP, 2'h0};
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic        power_state_input = 1'b0;
    logic        discontinuous_conduction = 1'b0;
    logic [7:0]  pwm_tristate = 8'h00;
    logic [7:0]  zero_cross = 8'h00;
    logic [7:0]  phase_oc_flag = 8'hA5;
    logic [31:0] prdata, rd_v;
    logic        pready, pslverr, oc_analog_en, resistive_hold_drive, err_v;
    logic [1:0]  ref_filter_sel, dem_pulldown_code;
    logic [2:0]  ccm_pulldown_code;
    logic [7:0]  output_sense_pd_en, oc_flag_out, brief_midlevel_drive;
    logic [3:0]  active_phases, ramp_code;
    int          fails = 0;
    int          num_checks = 0;
    logic [31:0] regs [6] = '{A_SHED, A_SCR, A_FILT, A_OC, A_MID, A_PH};
    logic [31:0] rstv [6] = '{32'(`PCR_RST_SHED_TIME), 32'(`PCR_RST_SCRATCH),
        32'(`PCR_RST_FILT_PD), 32'(`PCR_RST_OC_EN), 32'(`PCR_RST_MID_DRV), 32'(`PCR_RST_PH_RAMP)};
    logic [31:0] keep [6] = '{32'h13, 32'hA5, 32'h7F, 32'h2, 32'h2, 32'h7F};

    always #10 clk = ~clk;

    pcr_regs dut (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .power_state_input, .discontinuous_conduction, .pwm_tristate, .zero_cross,
        .phase_oc_flag, .ref_filter_sel, .ccm_pulldown_code, .dem_pulldown_code,
        .output_sense_pd_en, .oc_analog_en, .oc_flag_out, .resistive_hold_drive,
        .brief_midlevel_drive, .active_phases, .ramp_code);

    // ==========================================================
    // Tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Waits for pready; the request stands until it is seen, the watchdog ends a hang
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd_v = prdata;
        err_v = pslverr;
        chk("pready", 32'h1, 32'(pready));
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk("read data", exp, rd_v);
        chk("read error", 32'h0, 32'(err_v));
    endtask : rchk
    task automatic settle;
        repeat (6) @(posedge clk);
    endtask : settle
    task automatic zc_pulse(input logic [31:0] exp);
        int cnt;
        cnt = 0;
        @(posedge clk);
        zero_cross <= 8'h02;
        repeat (30) begin
            @(posedge clk);
            if (brief_midlevel_drive[1] === 1'b1) cnt++;
        end
        zero_cross <= 8'h00;
        settle();
        chk("brief drive cycles", exp, 32'(cnt));
    endtask : zc_pulse
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    // ==========================================================
    // Tests
    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        settle();
        for (int i = 0; i < 6; i++) rchk(regs[i], rstv[i]);
        chk("ref_filter_sel", 32'h1, 32'(ref_filter_sel));
        chk("oc_analog_en", 32'h0, 32'(oc_analog_en));
        chk("oc_flag_out", 32'h0, 32'(oc_flag_out));
        chk("resistive_hold_drive", 32'h0, 32'(resistive_hold_drive));
        chk("active_phases", 32'h1, 32'(active_phases));
        $display("test reset values done");
        for (int k = 0; k < 8; k++) begin
            wr(A_FILT, {25'h0, k[1:0], k[2:0], k[1:0]});
            wr(A_PH, {25'h0, k[2:0], k[2:0], k[0]});
            settle();
            chk("ref_filter_sel", 32'(k[1:0]), 32'(ref_filter_sel));
            chk("ccm_pulldown_code", 32'(k[2:0]), 32'(ccm_pulldown_code));
            chk("dem_pulldown_code", 32'(k[1:0]), 32'(dem_pulldown_code));
            chk("active_phases", 32'(k + 1), 32'(active_phases));
            chk("ramp_code", 32'({k[2:0], k[0]}), 32'(ramp_code));
        end
        wr(A_OC, 32'h3);
        wr(A_MID, 32'h2);
        wr(A_SCR, 32'hA5);
        settle();
        chk("oc_analog_en", 32'h1, 32'(oc_analog_en));
        chk("oc_flag_out", 32'hA5, 32'(oc_flag_out));
        chk("resistive_hold_drive", 32'h1, 32'(resistive_hold_drive));
        wr(A_OC, 32'h2);
        settle();
        chk("oc_flag_out", 32'h0, 32'(oc_flag_out));
        $display("test field codes done");
        wr(A_LOCK, 32'hA6);
        for (int i = 0; i < 6; i++) wr(regs[i], 32'h0);
        for (int i = 0; i < 6; i++) rchk(regs[i], keep[i]);
        wr(A_LOCK, 32'hA7);
        wr(A_SCR, 32'h5A);
        rchk(A_SCR, 32'h5A);
        $display("test lock done");
        wr(A_SHED, 32'h3F);
        rchk(A_SHED, 32'h13);
        wr(A_OVR, 32'h4);
        wr(A_SHED, 32'h2A);
        rchk(A_SHED, 32'h2A);
        wr(A_OVR, 32'h0);
        power_state_input <= 1'b1;
        settle();
        wr(A_SHED, 32'h15);
        rchk(A_SHED, 32'h15);
        chk("active_phases", 32'h8, 32'(active_phases));
        wr(A_LOCK, 32'hA6);
        wr(A_SHED, 32'h0);
        rchk(A_SHED, 32'h15);
        wr(A_LOCK, 32'h0);
        rchk({22'h0, `PCR_OFF_STATUS, 2'h0}, 32'hE00);
        apb(1'b0, 32'h200, 32'h0);
        chk("unmapped error", 32'h1, 32'(err_v));
        chk("unmapped data", 32'h0, rd_v);
        $display("test shed timing done");
        chk("output_sense_pd_en", 32'hFF, 32'(output_sense_pd_en));
        discontinuous_conduction <= 1'b1;
        pwm_tristate <= 8'h01;
        repeat (1900) @(posedge clk);
        chk("output_sense_pd_en", 32'h0, 32'(output_sense_pd_en));
        repeat (200) @(posedge clk);
        chk("output_sense_pd_en", 32'h1, 32'(output_sense_pd_en));
        zc_pulse(32'd0);
        wr(A_MID, 32'h1);
        zc_pulse(32'd10);
        $display("test conduction timing done");
        tally_and_finish();
    end

    // Tests need under 4000 cycles; this cuts a hang short
    initial begin
        repeat (12000) @(posedge clk);
        fails++;
        tally_and_finish();
    end
endmodule : tb_pcr_regs
